//--- src/dcfid_defs.svh
// Offsets, field positions and reset values of the feature registers
`ifndef DCFID_DEFS_SVH
`define DCFID_DEFS_SVH

`define DCFID_OFF_TX_FEAT    12'h008
`define DCFID_OFF_RX_FEAT    12'h00C
`define DCFID_OFF_DATA       12'h020
`define DCFID_OFF_DATA_BLK   12'h030

`define DCFID_FD_MSB         19
`define DCFID_FD_LSB         16
`define DCFID_SZ32_BIT       10
`define DCFID_SZ16_BIT       9
`define DCFID_SZ8_BIT        8
`define DCFID_W_MSB          7
`define DCFID_W_LSB          4
`define DCFID_IRQ_BIT        1
`define DCFID_PRES_BIT       0

`define DCFID_FD_RST         4'h0
`define DCFID_SZ32_RST       1'h1
`define DCFID_SZ16_RST       1'h0
`define DCFID_SZ8_RST        1'h0
`define DCFID_W_RST          4'h1
`define DCFID_PRES_RST       1'h1

// Edges to wait after reset before the tie-offs are captured
`define DCFID_CAP_WAIT       2'h2

`define DCFID_W_ONE          4'h1
`define DCFID_W_TWO          4'h2
`define DCFID_W_FOUR         4'h4

`endif

//--- src/dcfid_pkg.sv
// Types shared by the feature identification block
package dcfid_pkg;
   typedef enum logic [1:0] {
      DCFID_PH_IDLE  = 2'b00,
      DCFID_PH_READ  = 2'b01,
      DCFID_PH_WRITE = 2'b10
   } dcfid_phase_t;
endpackage

//--- src/dcfid_sync.sv
// Two-flop synchroniser for the tie-off inputs
`timescale 1ns/1ps
module dcfid_sync (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic d,
   output logic      q
);
   typedef struct packed {
      logic s1;
      logic s2;
   } dcfid_sync_t;

   dcfid_sync_t st_reg;
   dcfid_sync_t st_next;

   always_comb begin
      st_next.s1 = d;
      st_next.s2 = st_reg.s1;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign q = st_reg.s2;
endmodule

//--- src/dcfid_mask.sv
// Lane mask for data writes by transmit width
`timescale 1ns/1ps
`include "dcfid_defs.svh"
module dcfid_mask (
   input  wire logic [3:0]  width,
   input  wire logic [31:0] din,
   output logic      [31:0] dout
);
   always_comb begin
      case (width)
         `DCFID_W_ONE:  dout = {24'h000000, din[7:0]};   // [R7]
         `DCFID_W_TWO:  dout = {16'h0000, din[15:0]};    // [R8]
         default:       dout = din;
      endcase
   end
endmodule

//--- src/dcfid_regs.sv
// Feature identification registers behind an AHB-Lite slave
`timescale 1ns/1ps
`include "dcfid_defs.svh"

// Summary of operation
// R1 - Transmit register bits 19:16 give log2 of transmit FIFO bytes, reset 0.
// R2 - Receive register bits 19:16 give log2 of receive FIFO bytes, reset 0.
// R3 - Transmit bit 10 flags 32-bit write support, reset 1.
// R4 - Transmit bit 9 flags 16-bit write support, reset 0.
// R5 - Transmit bit 8 flags 8-bit write support, reset 0.
// R6 - Transmit bits 7:4 encode lane width 1, 2 or 4 bytes; reset 1.
// R7 - One-byte width drops bits 31:8 of data register writes.
// R8 - Two-byte width drops bits 31:16 of data register writes.
// R9 - Transmit bit 1 loads from the synchronised transmit interrupt tie-off on the third edge after reset.
// R10 - Transmit bit 0 reads 1: transmit engine present.
// R11 - Receive bits 10, 9, 8 flag 32/16/8-bit access, reset 1, 0, 0.
// R12 - Receive bit 1 loads from the synchronised receive interrupt tie-off on the third edge after reset.
// R13 - Receive bit 0 reads 1: receive engine present.
// R14 - Receive feature word is read-only at offset 0x0C.
// R15 - Transmit feature word is read-only at offset 0x08.
// R16 - Reserved bits read zero; writes to feature words are ignored.
module dcfid_regs (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [11:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   input  wire logic        tx_irq_tieoff,
   input  wire logic        rx_irq_tieoff,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] tx_data_word,
   output logic             tx_data_valid,
   output logic             tx_data_blocking
);
   typedef struct packed {
      dcfid_pkg::dcfid_phase_t phase;
      logic [11:0]             addr;
      logic                    cap_done;
      logic [1:0]              cap_cnt;
      logic                    tx_irq_present;
      logic                    rx_irq_present;
      logic [31:0]             rdata;
      logic [31:0]             wdata;
      logic                    wvalid;
      logic                    wblk;
   } dcfid_state_t;

   dcfid_state_t st_reg;
   dcfid_state_t st_next;

   logic        tx_tie_s;
   logic        rx_tie_s;
   logic [31:0] tx_feat;
   logic [31:0] rx_feat;
   logic [31:0] masked;
   logic        take;
   logic [3:0]  tx_lane_width;

   // Tie-offs may come from another domain, so synchronise first
   dcfid_sync u_tx_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .d       (tx_irq_tieoff),
      .q       (tx_tie_s)
   );
   dcfid_sync u_rx_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .d       (rx_irq_tieoff),
      .q       (rx_tie_s)
   );

   assign tx_lane_width = `DCFID_W_RST;   // [R6]

   dcfid_mask u_mask (
      .width (tx_lane_width),
      .din   (hwdata),
      .dout  (masked)
   );

   always_comb begin
      tx_feat = 32'h00000000;   // [R16]
      tx_feat[`DCFID_FD_MSB:`DCFID_FD_LSB] = `DCFID_FD_RST;   // [R1]
      tx_feat[`DCFID_SZ32_BIT] = `DCFID_SZ32_RST;   // [R3]
      tx_feat[`DCFID_SZ16_BIT] = `DCFID_SZ16_RST;   // [R4]
      tx_feat[`DCFID_SZ8_BIT] = `DCFID_SZ8_RST;   // [R5]
      tx_feat[`DCFID_W_MSB:`DCFID_W_LSB] = tx_lane_width;   // [R6]
      tx_feat[`DCFID_IRQ_BIT] = st_reg.tx_irq_present;   // [R9]
      tx_feat[`DCFID_PRES_BIT] = `DCFID_PRES_RST;   // [R10]
      rx_feat = 32'h00000000;   // [R16]
      rx_feat[`DCFID_FD_MSB:`DCFID_FD_LSB] = `DCFID_FD_RST;   // [R2]
      rx_feat[`DCFID_SZ32_BIT] = `DCFID_SZ32_RST;   // [R11]
      rx_feat[`DCFID_SZ16_BIT] = `DCFID_SZ16_RST;   // [R11]
      rx_feat[`DCFID_SZ8_BIT] = `DCFID_SZ8_RST;   // [R11]
      rx_feat[`DCFID_IRQ_BIT] = st_reg.rx_irq_present;   // [R12]
      rx_feat[`DCFID_PRES_BIT] = `DCFID_PRES_RST;   // [R13]
   end

   assign take = hsel && hready && htrans[1];

   always_comb begin
      st_next = st_reg;
      st_next.wvalid = 1'b0;
      // Tie-off captured once, after the synchroniser has filled;
      // capturing earlier would latch the flops' reset zero
      if (!st_reg.cap_done) begin
         if (st_reg.cap_cnt == `DCFID_CAP_WAIT) begin
            st_next.tx_irq_present = tx_tie_s;   // [R9]
            st_next.rx_irq_present = rx_tie_s;   // [R12]
            st_next.cap_done       = 1'b1;
         end else begin
            st_next.cap_cnt = st_reg.cap_cnt + 2'h1;
         end
      end
      // Data phase: writes to the data words are lane-masked
      if (st_reg.phase == dcfid_pkg::DCFID_PH_WRITE) begin
         if (st_reg.addr == `DCFID_OFF_DATA ||
             st_reg.addr == `DCFID_OFF_DATA_BLK) begin
            st_next.wdata  = masked;   // [R7] [R8]
            st_next.wvalid = 1'b1;
            st_next.wblk   = (st_reg.addr == `DCFID_OFF_DATA_BLK);
         end
         // Feature words have no write path at all
      end
      if (take) begin
         st_next.addr  = {haddr[11:2], 2'b00};
         st_next.phase = hwrite ? dcfid_pkg::DCFID_PH_WRITE
                                : dcfid_pkg::DCFID_PH_READ;
         case ({haddr[11:2], 2'b00})
            `DCFID_OFF_TX_FEAT: st_next.rdata = tx_feat;   // [R15]
            `DCFID_OFF_RX_FEAT: st_next.rdata = rx_feat;   // [R14]
            default:            st_next.rdata = 32'h00000000;
         endcase
      end else if (hready) begin
         st_next.phase = dcfid_pkg::DCFID_PH_IDLE;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign hrdata           = st_reg.rdata;
   assign hreadyout        = 1'b1;
   assign hresp            = 1'b0;
   assign tx_data_word     = st_reg.wdata;
   assign tx_data_valid    = st_reg.wvalid;
   assign tx_data_blocking = st_reg.wblk;

   a_tx_feat_const: assert property (@(posedge hclk) disable iff (!hresetn)
      take && !hwrite && haddr[11:2] == 10'h002 |=> // [R15]
      hrdata[31:2] == 30'h00000104)
      else $error("transmit feature word wrong");
   a_rx_feat_const: assert property (@(posedge hclk) disable iff (!hresetn)
      take && !hwrite && haddr[11:2] == 10'h003 |=> // [R14]
      hrdata[31:2] == 30'h00000100)
      else $error("receive feature word wrong");
   a_tx_irq_bit: assert property (@(posedge hclk) disable iff (!hresetn)
      st_reg.cap_done && take && !hwrite && haddr[11:2] == 10'h002 // [R9]
      |=> hrdata[1] == tx_tie_s)
      else $error("transmit interrupt bit wrong");
   a_rx_irq_bit: assert property (@(posedge hclk) disable iff (!hresetn)
      st_reg.cap_done && take && !hwrite && haddr[11:2] == 10'h003 // [R12]
      |=> hrdata[1] == rx_tie_s)
      else $error("receive interrupt bit wrong");
   a_irq_stable: assert property (@(posedge hclk) disable iff (!hresetn)
      $past(st_reg.cap_done) |-> $stable(st_reg.tx_irq_present) // [R16]
      && $stable(st_reg.rx_irq_present))
      else $error("feature bits changed");
   a_lane_mask: assert property (@(posedge hclk) disable iff (!hresetn)
      tx_data_valid |-> tx_data_word[31:8] == 24'h000000) // [R7]
      else $error("upper lanes not dropped");
   a_data_path: assert property (@(posedge hclk) disable iff (!hresetn)
      take && hwrite && haddr[11:2] == 10'h008 |=> ##1 // [R7]
      tx_data_valid && tx_data_word == {24'h000000, $past(hwdata[7:0])})
      else $error("data write lost");
   a_unmapped_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      take && !hwrite && haddr[11:2] != 10'h002 && // [R16]
      haddr[11:2] != 10'h003 |=> hrdata == 32'h00000000)
      else $error("unmapped read not zero");

   c_tx_read: cover property (@(posedge hclk)
      take && !hwrite && haddr[11:2] == 10'h002);
   c_rx_read: cover property (@(posedge hclk)
      take && !hwrite && haddr[11:2] == 10'h003);
   c_feat_write: cover property (@(posedge hclk)
      take && hwrite && haddr[11:2] == 10'h002);
   c_data_write: cover property (@(posedge hclk) tx_data_valid);
endmodule

//--- tb/dcfid_master.sv
// Debugger-side AHB-Lite master for single word transfers
`timescale 1ns/1ps
module dcfid_master (
   input  wire logic        hclk,
   input  wire logic        hready,
   output logic             hsel,
   output logic      [11:0] haddr,
   output logic      [1:0]  htrans,
   output logic             hwrite,
   output logic      [2:0]  hsize,
   output logic      [31:0] hwdata
);
   initial begin
      hsel = 1'h0;
      haddr = 12'h000;
      htrans = 2'h0;
      hwrite = 1'h0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
   end
   // Enter just after a rising edge; returns just after one
   task automatic xfer(input logic [11:0] a, input logic w,
                       input logic [31:0] d);
      hsel <= 1'h1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      // Reads get a changing pattern so stale data never looks valid
      hwdata <= w ? d : ~hwdata;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
   endtask
endmodule

//--- tb/dcfid_regs_bench.sv
// Self-checking bench for the feature identification registers
`timescale 1ns/1ps
module dcfid_regs_bench;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [11:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        tx_irq_tieoff;
   logic        rx_irq_tieoff;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] tx_data_word;
   logic        tx_data_valid;
   logic        tx_data_blocking;
   logic        rd_ph;
   logic        t;
   logic [31:0] d;
   logic [31:0] rd_q[$];
   logic [32:0] tx_q[$];
   int          fails;
   int          cmp_count;
   int          cycles;

   dcfid_regs dcfid_regs_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .tx_irq_tieoff(tx_irq_tieoff),
      .rx_irq_tieoff(rx_irq_tieoff), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .tx_data_word(tx_data_word),
      .tx_data_valid(tx_data_valid), .tx_data_blocking(tx_data_blocking));
   dcfid_master dcfid_master_i (.hclk(hclk), .hready(hreadyout),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata));

   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk_read(input logic [31:0] e);
      cmp_count++;
      if ({hresp, hrdata} !== {1'b0, e}) begin
         fails++;
         $display("ERROR hrdata expected %h seen %h", e, hrdata);
      end
   endtask
   task automatic chk_tx(input logic [32:0] e);
      cmp_count++;
      if ({tx_data_blocking, tx_data_word} !== e) begin
         fails++;
         $display("ERROR tx_data expected %h seen %h", e,
                  {tx_data_blocking, tx_data_word});
      end
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      dcfid_master_i.xfer(a, 1'b0, 32'h00000000);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      dcfid_master_i.xfer(a, 1'b1, v);
   endtask

   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end
   // Watcher: a read's data is due at the edge closing its data phase
   always @(posedge hclk) begin
      if (rd_ph === 1'b1 && hreadyout === 1'b1)
         chk_read(rd_q.pop_front());
      if (tx_data_valid === 1'b1)
         chk_tx(tx_q.pop_front());
      rd_ph <= hresetn & hsel & htrans[1] & ~hwrite & hreadyout;
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         fails++;
         report_and_stop();
      end
   end

   initial begin
      hresetn = 1'b0;
      tx_irq_tieoff = 1'b0;
      rx_irq_tieoff = 1'b0;
      rd_ph = 1'b0;
      fails = 0;
      cmp_count = 0;
      cycles = 0;
      void'($urandom(83));
      t = 1'($urandom);
      // Second pass resets mid-run with both tie-offs flipped
      for (int r = 0; r < 2; r++) begin
         hresetn <= 1'b0;
         tx_irq_tieoff <= t ^ r[0];
         rx_irq_tieoff <= ~(t ^ r[0]);
         repeat (3) @(posedge hclk);
         hresetn <= 1'b1;
         // Tie-off bits settle only from the third edge on
         repeat (4) @(posedge hclk);
         rd(12'h008, {30'h00000104, tx_irq_tieoff, 1'b1});
         rd(12'h00C, {30'h00000100, rx_irq_tieoff, 1'b1});
         d = $urandom;
         wr(12'h008, d);
         wr(12'h00C, ~d);
         rd(12'h008, {30'h00000104, tx_irq_tieoff, 1'b1});
         rd(12'h00C, {30'h00000100, rx_irq_tieoff, 1'b1});
         rd(12'h104, 32'h00000000);
         tx_q.push_back({1'b0, 24'h000000, d[7:0]});
         wr(12'h020, d);
         tx_q.push_back({1'b1, 24'h000000, ~d[7:0]});
         wr(12'h030, ~d);
         repeat (3) @(posedge hclk);
      end
      report_and_stop();
   end
endmodule
